// ==== include/scir_pkg.sv ====
package scir_pkg;

    // Register addresses on the four-bit host address bus.
    localparam logic [3:0] ADDR_TIMER  = 4'hC;
    localparam logic [3:0] ADDR_STATUS = 4'hD;
    localparam logic [3:0] ADDR_INTERRUPT_STATUS   = 4'hE;

    localparam logic [7:0] STATUS_RST = 8'h05;
    localparam logic [7:0] INTERRUPT_STATUS_RST   = 8'h00;

    // Status bit positions.
    localparam int ST_MEM_BUSY  = 7;
    localparam int ST_TIMER_RUN = 6;
    localparam int ST_PCM_SYNC  = 5;
    localparam int ST_MON_BUSY  = 4;
    localparam int ST_MON_ABORT = 3;
    localparam int ST_MF_ACCESS = 2;
    localparam int ST_MF_DIR    = 1;
    localparam int ST_MF_EMPTY  = 0;

    // Command bit positions.
    localparam int CMD_TIMER_START = 6;
    localparam int CMD_TIMER_IRQ   = 5;
    localparam int CMD_SIG_RESET   = 4;
    localparam int CMD_MON_HI      = 3;
    localparam int CMD_MON_LO      = 2;
    localparam int CMD_SEARCH      = 1;
    localparam int CMD_MON_RESET   = 0;

    // Interrupt status bit positions.
    localparam int IRQ_TIMER  = 7;
    localparam int IRQ_SIG    = 6;
    localparam int IRQ_MON    = 5;
    localparam int IRQ_ACTIVE = 4;
    localparam int IRQ_PCM    = 3;
    localparam int IRQ_SYNC   = 1;
    localparam int IRQ_OVFL   = 0;
    localparam logic [7:0] IRQ_LEVEL_BITS = 8'h40;
    localparam logic [7:0] IRQ_USED_BITS  = 8'hFB;

    // Timer base step and its length in clock cycles.
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int TIMER_STEP_US  = 250;
    localparam int TIMER_STEP_CYC = TIMER_STEP_US * 1000000 / CLK_PERIOD_PS;

    // Cycles the signaling flag is forced low after a FIFO reset.
    localparam logic [1:0] SIG_RESET_HOLD = 2'h2;

    // Monitor command codes and expected byte counts.
    localparam logic [1:0] MON_IDLE   = 2'h0;
    localparam logic [1:0] MON_TX     = 2'h1;
    localparam logic [1:0] MON_TXRX   = 2'h2;
    localparam logic [1:0] MON_LINE   = 2'h3;
    localparam logic [4:0] MON_BYTES1  = 5'h01;
    localparam logic [4:0] MON_BYTES2  = 5'h02;
    localparam logic [4:0] MON_BYTES8  = 5'h08;
    localparam logic [4:0] MON_BYTES16 = 5'h10;
    localparam logic [4:0] MON_BYTESANY = 5'h00;

endpackage

// ==== hdl/periodic_timer.sv ====
`timescale 1ns/1ps
module periodic_timer #(
    parameter int STEP_CYC = scir_pkg::TIMER_STEP_CYC
) (
    input  wire logic       clk_i,      // System clock.
    input  wire logic       sys_rst_i,  // Synchronous reset.
    input  wire logic       start_i,    // Start pulse.
    input  wire logic       irq_en_i,   // Interrupt enable taken with start.
    input  wire logic       stop_i,     // Stop pulse.
    input  wire logic       mode_ok_i,  // Operating mode bit zero.
    input  wire logic [6:0] period_i,   // Final count value.
    output logic            running_o,  // Timer runs.
    output logic            expire_o    // Expiry pulse when enabled.
);

    typedef struct packed {
        logic        run;
        logic        irq_en;
        logic [31:0] step;
        logic [6:0]  count;
        logic        expire;
    } tmr_t;

    tmr_t tmr_r;
    tmr_t tmr_nxt;

    always_comb
    begin
        tmr_nxt        = tmr_r;
        tmr_nxt.expire = 1'b0;
        if (tmr_r.run)
        begin
            if (tmr_r.step == 32'(STEP_CYC - 1))
            begin
                tmr_nxt.step = '0;
                if (tmr_r.count == period_i)
                begin
                    tmr_nxt.count  = '0;
                    tmr_nxt.expire = tmr_r.irq_en;
                end
                else
                begin
                    tmr_nxt.count = tmr_r.count + 7'h01;
                end
            end
            else
            begin
                tmr_nxt.step = tmr_r.step + 32'h0000_0001;
            end
        end
        if (start_i)
        begin
            tmr_nxt.run    = 1'b1;
            tmr_nxt.irq_en = irq_en_i;
            tmr_nxt.step   = '0;
            tmr_nxt.count  = '0;
        end
        if (stop_i || !mode_ok_i)
        begin
            tmr_nxt.run    = 1'b0;
            tmr_nxt.expire = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tmr_r <= '0;
        end
        else
        begin
            tmr_r <= tmr_nxt;
        end
    end

    assign running_o = tmr_r.run;
    assign expire_o  = tmr_r.expire;

endmodule

// ==== hdl/irq_status_bits.sv ====
`timescale 1ns/1ps
module irq_status_bits (
    input  wire logic       clk_i,      // System clock.
    input  wire logic       sys_rst_i,  // Synchronous reset.
    input  wire logic [7:0] set_i,      // Event pulses per bit.
    input  wire logic [7:0] level_i,    // Live level for level bits.
    input  wire logic [7:0] clr_i,      // Clear on read per bit.
    output logic      [7:0] flags_o     // Held flags.
);

    typedef struct packed {
        logic [7:0] flags;
    } flg_t;

    flg_t       flg_r;
    flg_t       flg_nxt;
    logic [7:0] bit_nxt;

    genvar b;
    generate
        for (b = 0; b < 8; b++)
        begin : g_bit
            if (scir_pkg::IRQ_LEVEL_BITS[b])
            begin : g_lvl
                assign bit_nxt[b] = level_i[b];
            end
            else if (scir_pkg::IRQ_USED_BITS[b])
            begin : g_sticky
                // A new event wins over a clear in the same cycle.
                assign bit_nxt[b] = set_i[b] |
                    (flg_r.flags[b] & ~clr_i[b]);
            end
            else
            begin : g_none
                assign bit_nxt[b] = 1'b0;
            end
        end
    endgenerate

    always_comb
    begin
        flg_nxt.flags = bit_nxt;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            flg_r.flags <= scir_pkg::INTERRUPT_STATUS_RST;
        end
        else
        begin
            flg_r <= flg_nxt;
        end
    end

    assign flags_o = flg_r.flags;

endmodule

// ==== hdl/status_command_irq_regs.sv ====
`timescale 1ns/1ps
module status_command_irq_regs #(
    parameter int STEP_CYC = scir_pkg::TIMER_STEP_CYC
) (
    input  wire logic       clk_i,          // System clock.
    input  wire logic       sys_rst_i,      // Synchronous reset.
    input  wire logic [3:0] addr_i,         // Host register address.
    input  wire logic       wr_en_i,        // Host write strobe.
    input  wire logic       rd_en_i,        // Host read strobe.
    input  wire logic [7:0] wdata_i,        // Host write data.
    output logic      [7:0] rdata_o,        // Host read data.
    output logic            irq_o,          // Interrupt, active high.
    input  wire logic [7:0] irq_mask_i,     // Mask, 1 disables.
    input  wire logic       operating_mode_bit_zero_i, // Mode bit zero.
    input  wire logic       handshake_select_i,   // Handshake enabled.
    input  wire logic [7:0] subscriber_select_reg_i, // Slot select.
    input  wire logic [6:0] timer_period_value_i, // Timer final count.
    input  wire logic       memory_access_busy_i, // Memory access runs.
    input  wire logic       pcm_locked_i,         // Framing matches.
    input  wire logic       mon_busy_i,           // Transfer runs.
    input  wire logic       mon_aborted_i,        // Remote abort seen.
    input  wire logic       mon_fifo_access_ok_i, // FIFO accessible.
    input  wire logic       mon_fifo_direction_i, // 1 readable.
    input  wire logic       mon_fifo_empty_i,     // FIFO empty.
    input  wire logic       mon_done_i,           // Command done pulse.
    input  wire logic       sig_fifo_not_empty_i, // Valid entry held.
    input  wire logic       sync_chan_enabled_i,  // A sync channel on.
    input  wire logic       sync_window_open_i,   // Window opens pulse.
    input  wire logic       sync_window_missed_i, // Window missed pulse.
    input  wire logic       mx_valid_i,           // MX sample valid.
    input  wire logic [5:0] mx_slot_i,            // Slot of MX sample.
    input  wire logic       mx_bit_i,             // Received MX bit.
    output logic            sig_fifo_reset_o,     // FIFO clear pulse.
    output logic            mon_fifo_reset_o,     // FIFO clear pulse.
    output logic            mon_start_o,          // Transfer start pulse.
    output logic      [1:0] mon_cmd_o,            // Transfer code.
    output logic      [5:0] mon_slot_o,           // Addressed slot.
    output logic      [1:0] mon_variant_o,        // Upper select bits.
    output logic      [4:0] mon_expect_o,         // Bytes, 0 for any.
    output logic            mon_continuous_o,     // Continuous transmit.
    output logic            search_on_o,          // Search running.
    output logic      [5:0] active_channel_o,     // Found slot.
    output logic            timer_running_o       // Timer runs.
);

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] rdata;
        logic       tstart;
        logic       tirq;
        logic       tstop;
        logic       sig_rst;
        logic [1:0] sig_hold;
        logic       mon_rst;
        logic       mon_start;
        logic [1:0] mon_cmd;
        logic [5:0] mon_slot;
        logic [1:0] mon_var;
        logic [4:0] mon_exp;
        logic       mon_cont;
        logic       search;
        logic [5:0] act_slot;
        logic       found;
        logic       pss_prev;
    } regs_t;

    regs_t      r_r;
    regs_t      r_nxt;
    logic       wr_cmd;
    logic       wr_timer;
    logic       rd_interrupt_status;
    logic       pcm_sync_state;
    logic       timer_expire;
    logic       timer_running;
    logic [7:0] flags;
    logic [7:0] interrupt_status_view;
    logic [7:0] irq_set;
    logic [7:0] irq_lvl;
    logic [7:0] irq_clr;

    assign wr_cmd   = wr_en_i && (addr_i == scir_pkg::ADDR_STATUS);
    assign wr_timer = wr_en_i && (addr_i == scir_pkg::ADDR_TIMER);
    assign rd_interrupt_status  = rd_en_i && (addr_i == scir_pkg::ADDR_INTERRUPT_STATUS);

    assign pcm_sync_state = pcm_locked_i && operating_mode_bit_zero_i;

    // Masked flags stay held and appear once unmasked; signaling shows always.
    assign interrupt_status_view = flags & (~irq_mask_i | scir_pkg::IRQ_LEVEL_BITS);

    always_comb
    begin
        irq_set = '0;
        irq_set[scir_pkg::IRQ_TIMER]  = timer_expire;
        irq_set[scir_pkg::IRQ_MON]    = mon_done_i;
        irq_set[scir_pkg::IRQ_ACTIVE] = r_r.found;
        irq_set[scir_pkg::IRQ_PCM]    = pcm_sync_state ^ r_r.pss_prev;
        irq_set[scir_pkg::IRQ_SYNC]   = sync_window_open_i &&
                                        sync_chan_enabled_i;
        irq_set[scir_pkg::IRQ_OVFL]   = sync_window_missed_i;
        irq_lvl = '0;
        irq_lvl[scir_pkg::IRQ_SIG] = sig_fifo_not_empty_i &&
                                     (r_r.sig_hold == 2'h0) &&
                                     !r_r.sig_rst;
        irq_clr = rd_interrupt_status ? (interrupt_status_view & ~scir_pkg::IRQ_LEVEL_BITS) : 8'h00;
    end

    always_comb
    begin
        r_nxt           = r_r;
        r_nxt.tstart    = 1'b0;
        r_nxt.tstop     = wr_timer;
        r_nxt.sig_rst   = 1'b0;
        r_nxt.mon_rst   = 1'b0;
        r_nxt.mon_start = 1'b0;
        r_nxt.found     = 1'b0;
        r_nxt.pss_prev  = pcm_sync_state;

        // Live status snapshot; reads never alter it.
        r_nxt.status[scir_pkg::ST_MEM_BUSY]  = memory_access_busy_i;
        r_nxt.status[scir_pkg::ST_TIMER_RUN] = timer_running;
        r_nxt.status[scir_pkg::ST_PCM_SYNC]  = pcm_sync_state;
        r_nxt.status[scir_pkg::ST_MON_BUSY]  = mon_busy_i;
        r_nxt.status[scir_pkg::ST_MON_ABORT] = mon_aborted_i;
        r_nxt.status[scir_pkg::ST_MF_ACCESS] = mon_fifo_access_ok_i;
        r_nxt.status[scir_pkg::ST_MF_DIR]    = mon_fifo_direction_i;
        r_nxt.status[scir_pkg::ST_MF_EMPTY]  = mon_fifo_empty_i;

        if (r_r.sig_hold != 2'h0)
        begin
            r_nxt.sig_hold = r_r.sig_hold - 2'h1;
        end

        if (rd_en_i)
        begin
            case (addr_i)
                scir_pkg::ADDR_STATUS: r_nxt.rdata = r_r.status;
                scir_pkg::ADDR_INTERRUPT_STATUS:   r_nxt.rdata = interrupt_status_view;
                default:               r_nxt.rdata = 8'h00;
            endcase
        end

        // Search: stop on first slot with MX low or when mode bit drops.
        if (r_r.search && mx_valid_i && !mx_bit_i)
        begin
            r_nxt.search   = 1'b0;
            r_nxt.act_slot = mx_slot_i;
            r_nxt.found    = 1'b1;
        end

        if (wr_cmd)
        begin
            if (wdata_i[scir_pkg::CMD_TIMER_START])
            begin
                r_nxt.tstart = 1'b1;
                r_nxt.tirq   = wdata_i[scir_pkg::CMD_TIMER_IRQ];
            end
            if (wdata_i[scir_pkg::CMD_SIG_RESET])
            begin
                r_nxt.sig_rst  = 1'b1;
                r_nxt.sig_hold = scir_pkg::SIG_RESET_HOLD;
            end
            if (wdata_i[scir_pkg::CMD_SEARCH])
            begin
                r_nxt.search = 1'b1;
            end
            if (wdata_i[scir_pkg::CMD_MON_HI:scir_pkg::CMD_MON_LO]
                != scir_pkg::MON_IDLE)
            begin
                r_nxt.mon_start = 1'b1;
                r_nxt.mon_cmd   =
                    wdata_i[scir_pkg::CMD_MON_HI:scir_pkg::CMD_MON_LO];
                r_nxt.mon_slot  = subscriber_select_reg_i[5:0];
                r_nxt.mon_var   = subscriber_select_reg_i[7:6];
                r_nxt.mon_cont  = 1'b0;
                r_nxt.mon_exp   = scir_pkg::MON_BYTESANY;
                case (wdata_i[scir_pkg::CMD_MON_HI:scir_pkg::CMD_MON_LO])
                    scir_pkg::MON_TX:
                    begin
                        r_nxt.mon_exp = scir_pkg::MON_BYTESANY;
                    end
                    scir_pkg::MON_TXRX:
                    begin
                        if (!handshake_select_i)
                        begin
                            r_nxt.mon_exp =
                                byte_count(subscriber_select_reg_i[7:6]);
                        end
                    end
                    scir_pkg::MON_LINE:
                    begin
                        if (handshake_select_i)
                        begin
                            r_nxt.mon_cont = 1'b1;
                        end
                        else
                        begin
                            r_nxt.mon_exp =
                                byte_count(subscriber_select_reg_i[7:6]);
                        end
                    end
                    default:
                    begin
                        r_nxt.mon_exp = scir_pkg::MON_BYTESANY;
                    end
                endcase
            end
            if (wdata_i[scir_pkg::CMD_MON_RESET])
            begin
                // Aborts any transfer; the search keeps running.
                r_nxt.mon_rst   = 1'b1;
                r_nxt.mon_start = 1'b0;
                r_nxt.mon_cmd   = scir_pkg::MON_IDLE;
            end
        end

        if (!operating_mode_bit_zero_i)
        begin
            r_nxt.search = 1'b0;
        end
    end

    function automatic logic [4:0] byte_count(input logic [1:0] sel);
        logic [4:0] n;
        case (sel)
            2'h0:    n = scir_pkg::MON_BYTES1;
            2'h1:    n = scir_pkg::MON_BYTES2;
            2'h2:    n = scir_pkg::MON_BYTES8;
            default: n = scir_pkg::MON_BYTES16;
        endcase
        return n;
    endfunction

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            r_r          <= '0;
            r_r.status   <= scir_pkg::STATUS_RST;
        end
        else
        begin
            r_r <= r_nxt;
        end
    end

    periodic_timer #(
        .STEP_CYC (STEP_CYC)
    ) u_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .start_i   (r_r.tstart),
        .irq_en_i  (r_r.tirq),
        .stop_i    (r_r.tstop),
        .mode_ok_i (operating_mode_bit_zero_i),
        .period_i  (timer_period_value_i),
        .running_o (timer_running),
        .expire_o  (timer_expire)
    );

    irq_status_bits u_flags (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .set_i     (irq_set),
        .level_i   (irq_lvl),
        .clr_i     (irq_clr),
        .flags_o   (flags)
    );

    assign irq_o            = |(flags & ~irq_mask_i);
    assign rdata_o          = r_r.rdata;
    assign sig_fifo_reset_o = r_r.sig_rst;
    assign mon_fifo_reset_o = r_r.mon_rst;
    assign mon_start_o      = r_r.mon_start;
    assign mon_cmd_o        = r_r.mon_cmd;
    assign mon_slot_o       = r_r.mon_slot;
    assign mon_variant_o    = r_r.mon_var;
    assign mon_expect_o     = r_r.mon_exp;
    assign mon_continuous_o = r_r.mon_cont;
    assign search_on_o      = r_r.search;
    assign active_channel_o = r_r.act_slot;
    assign timer_running_o  = timer_running;

endmodule

// ==== verif/scir_checker.sv ====
`timescale 1ns/1ps
module scir_checker (
    input wire logic       clk_i,
    input wire logic       sys_rst_i,
    input wire logic [3:0] addr_i,
    input wire logic       wr_en_i,
    input wire logic       rd_en_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic       irq_o,
    input wire logic [7:0] irq_mask_i,
    input wire logic       operating_mode_bit_zero_i,
    input wire logic       memory_access_busy_i,
    input wire logic       pcm_locked_i,
    input wire logic       mon_busy_i,
    input wire logic       mon_fifo_empty_i,
    input wire logic       sig_fifo_reset_o,
    input wire logic       mon_fifo_reset_o,
    input wire logic       mon_start_o,
    input wire logic [1:0] mon_cmd_o,
    input wire logic       timer_running_o
);
    logic       cmd_wr;
    logic       sta_rd;
    logic [1:0] wcode;
    assign cmd_wr = wr_en_i && addr_i == scir_pkg::ADDR_STATUS;
    assign sta_rd = rd_en_i && addr_i == scir_pkg::ADDR_STATUS;
    assign wcode = wdata_i[3:2];
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    chk_sig_reset_pulse: assert property (
        cmd_wr && wdata_i[scir_pkg::CMD_SIG_RESET] |=> sig_fifo_reset_o)
        else $error("signaling reset pulse missing");
    chk_zero_no_reset: assert property (
        !(cmd_wr && wdata_i[scir_pkg::CMD_SIG_RESET]) |=> !sig_fifo_reset_o)
        else $error("signaling reset without command");
    chk_mon_reset_wins: assert property (
        cmd_wr && wdata_i[scir_pkg::CMD_MON_RESET]
        |=> mon_fifo_reset_o && !mon_start_o)
        else $error("monitor reset pulse wrong");
    chk_mon_start_code: assert property (
        cmd_wr && wcode != 2'h0 && !wdata_i[scir_pkg::CMD_MON_RESET]
        |=> mon_start_o && mon_cmd_o == $past(wcode))
        else $error("monitor start or code wrong");
    chk_timer_starts: assert property (
        cmd_wr && wdata_i[scir_pkg::CMD_TIMER_START]
        && operating_mode_bit_zero_i ##1 operating_mode_bit_zero_i
        |=> timer_running_o)
        else $error("timer did not start");
    chk_timer_stops: assert property (
        wr_en_i && addr_i == scir_pkg::ADDR_TIMER |=> ##1 !timer_running_o)
        else $error("timer did not stop");
    chk_status_mem: assert property (
        sta_rd |=> rdata_o[7] == $past(memory_access_busy_i, 2))
        else $error("memory busy status wrong");
    chk_status_fifo: assert property (
        sta_rd |=> rdata_o[0] == $past(mon_fifo_empty_i, 2)
        && rdata_o[4] == $past(mon_busy_i, 2))
        else $error("monitor status wrong");
    chk_status_pcm: assert property (
        sta_rd |=> rdata_o[5] == ($past(pcm_locked_i, 2)
        && $past(operating_mode_bit_zero_i, 2)))
        else $error("pcm sync status wrong");
    chk_masked_quiet: assert property (
        irq_mask_i == 8'hFF |-> !irq_o)
        else $error("interrupt while all masked");
endmodule
bind status_command_irq_regs scir_checker chk (.*);

// ==== verif/host_bus_model.sv ====
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic       clk_i,   // System clock.
    output logic      [3:0] addr_o,  // Register address.
    output logic            wr_en_o, // Write strobe.
    output logic            rd_en_o, // Read strobe.
    output logic      [7:0] wdata_o  // Write data.
);
    initial
    begin
        addr_o = 4'h0;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        wdata_o = 8'h00;
    end
    // Address and data lines are inverted and strobes dropped after each access so stale values never match.
    task automatic access(input logic w, input logic [3:0] a,
                          input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wr_en_o <= w;
        rd_en_o <= !w;
        wdata_o <= {1'b0, d[6:0]};
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        rd_en_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    localparam logic [3:0] SR = scir_pkg::ADDR_STATUS;
    localparam logic [3:0] IR = scir_pkg::ADDR_INTERRUPT_STATUS;
    logic       clk_i, sys_rst_i, wr_en_i, rd_en_i, irq_o, rd_seen;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o, irq_mask_i, subscriber_select_reg_i, e;
    logic       operating_mode_bit_zero_i, handshake_select_i, ps, pf, ns;
    logic [6:0] timer_period_value_i;
    logic       memory_access_busy_i, pcm_locked_i, mon_busy_i;
    logic       mon_aborted_i, mon_fifo_access_ok_i, mon_fifo_direction_i;
    logic       mon_fifo_empty_i, mon_done_i, sig_fifo_not_empty_i;
    logic       sync_chan_enabled_i, sync_window_open_i;
    logic       sync_window_missed_i, mx_valid_i, mx_bit_i;
    logic [5:0] mx_slot_i, mon_slot_o, active_channel_o;
    logic       sig_fifo_reset_o, mon_fifo_reset_o, mon_start_o;
    logic [1:0] mon_cmd_o, mon_variant_o;
    logic [4:0] mon_expect_o, eb;
    logic       mon_continuous_o, search_on_o, timer_running_o;
    logic [31:0] seed;
    logic [7:0]  rq[$];
    logic [15:0] mq[$];
    int          mismatches, n_tests;
    status_command_irq_regs #(.STEP_CYC(4)) dut (.*);
    host_bus_model host (.clk_i, .addr_o(addr_i), .wr_en_o(wr_en_i),
                         .rd_en_o(rd_en_i), .wdata_o(wdata_i));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input string nm, input logic [15:0] s,
                         input logic [15:0] x);
        n_tests++;
        if (s !== x)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        rq.push_back(x);
        host.access(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask
    task automatic chk_irq(input logic x);
        @(negedge clk_i);
        check("irq_o", {15'h0, irq_o}, {15'h0, x});
    endtask
    always @(posedge clk_i)
    begin
        if (rd_seen === 1'b1)
            check("rdata_o", {8'h0, rdata_o},
                  {8'h0, rq.size() > 0 ? rq.pop_front() : 8'hxx});
        if (mon_start_o === 1'b1)
            check("monitor fields", {mon_cmd_o, mon_variant_o, mon_expect_o,
                  mon_continuous_o, mon_slot_o},
                  mq.size() > 0 ? mq.pop_front() : 16'hxxxx);
        rd_seen <= rd_en_i;
    end
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        conclude();
    end
    initial
    begin
        seed = 32'he030_63e2;
        {mismatches, n_tests, rd_seen, sys_rst_i} = {32'h0, 32'h0, 2'b01};
        {irq_mask_i, subscriber_select_reg_i} = 16'h0000;
        {operating_mode_bit_zero_i, handshake_select_i} = 2'b10;
        timer_period_value_i = 7'h02;
        {memory_access_busy_i, pcm_locked_i, mon_busy_i, mon_aborted_i,
         mon_fifo_access_ok_i, mon_fifo_direction_i, mon_fifo_empty_i} = 7'h05;
        {mon_done_i, sig_fifo_not_empty_i, sync_chan_enabled_i, mx_bit_i,
         sync_window_open_i, sync_window_missed_i, mx_valid_i} = 7'h00;
        mx_slot_i = 6'h00;
        tick(2);
        sys_rst_i <= 1'b0;
        rd(SR, scir_pkg::STATUS_RST);
        rd(IR, scir_pkg::INTERRUPT_STATUS_RST);
        rd(4'h3, 8'h00);
        {ps, pf} = 2'b00;
        for (int i = 0; i < 9; i++)
        begin
            seed = xs(seed);
            e = (i == 8) ? 8'h85 : seed[7:0];
            {operating_mode_bit_zero_i, memory_access_busy_i, pcm_locked_i,
             mon_busy_i, mon_aborted_i, mon_fifo_access_ok_i,
             mon_fifo_direction_i, mon_fifo_empty_i} <= e;
            ns = e[7] & e[5];
            pf = pf | (ns != ps);
            ps = ns;
            tick(2);
            rd(SR, {e[6], 1'b0, ns, e[4:0]});
            rd(SR, {e[6], 1'b0, ns, e[4:0]});
        end
        rd(IR, {4'h0, pf, 3'h0});
        rd(IR, 8'h00);
        for (int c = 1; c < 4; c++)
            for (int h = 0; h < 2; h++)
                for (int u = 0; u < 4; u++)
                begin
                    if ((c == 1 && u == 3) || (h == 1 && c != 1 && u != 0))
                        continue;
                    seed = xs(seed);
                    eb = (c == 1 || h == 1) ? 5'h00
                       : 5'h01 << ((u == 3) ? 4 : (u == 2) ? 3 : u);
                    handshake_select_i <= h[0];
                    subscriber_select_reg_i <= {u[1:0], seed[5:0]};
                    mq.push_back({c[1:0], u[1:0], eb, c == 3 && h == 1,
                                  seed[5:0]});
                    tick(1);
                    wr(SR, {4'h0, c[1:0], 2'h0});
                end
        wr(SR, 8'h05);
        wr(SR, 8'h60);
        tick(40);
        rd(SR, 8'h45);
        chk_irq(1'b1);
        wr(scir_pkg::ADDR_TIMER, 8'h5a);
        tick(4);
        rd(SR, 8'h05);
        rd(IR, 8'h80);
        rd(IR, 8'h00);
        wr(SR, 8'h40);
        tick(40);
        wr(scir_pkg::ADDR_TIMER, 8'h00);
        tick(4);
        rd(IR, 8'h00);
        sig_fifo_not_empty_i <= 1'b1;
        tick(2);
        rd(IR, 8'h40);
        rd(IR, 8'h40);
        irq_mask_i <= 8'hff;
        tick(1);
        chk_irq(1'b0);
        rd(IR, 8'h40);
        wr(SR, 8'h10);
        rd(IR, 8'h00);
        sig_fifo_not_empty_i <= 1'b0;
        irq_mask_i <= 8'h20;
        mon_done_i <= 1'b1;
        tick(1);
        mon_done_i <= 1'b0;
        rd(IR, 8'h00);
        tick(1);
        irq_mask_i <= 8'h00;
        chk_irq(1'b1);
        rd(IR, 8'h20);
        chk_irq(1'b0);
        sync_window_open_i <= 1'b1;
        tick(1);
        sync_window_open_i <= 1'b0;
        rd(IR, 8'h00);
        sync_chan_enabled_i <= 1'b1;
        {sync_window_open_i, sync_window_missed_i} <= 2'b11;
        tick(1);
        {sync_window_open_i, sync_window_missed_i} <= 2'b00;
        rd(IR, 8'h03);
        rd(IR, 8'h00);
        wr(SR, 8'h02);
        wr(SR, 8'h01);
        {mx_valid_i, mx_bit_i, mx_slot_i} <= {2'b11, 6'h05};
        tick(1);
        {mx_valid_i, mx_bit_i, mx_slot_i} <= {2'b10, 6'h09};
        check("search_on_o", {15'h0, search_on_o}, 16'h0001);
        tick(1);
        mx_valid_i <= 1'b0;
        tick(3);
        rd(IR, 8'h10);
        check("active_channel_o", {10'h0, active_channel_o}, 16'h0009);
        check("search_on_o", {15'h0, search_on_o}, 16'h0000);
        rd(IR, 8'h00);
        tick(2);
        check("pending", 16'(rq.size() + mq.size()), 16'h0000);
        conclude();
    end
endmodule
